// file: verilog/bsp_regs.svh
// Constants of the split-port burst memory block
`ifndef BSP_REGS_SVH
`define BSP_REGS_SVH

// =====================================================================
// Geometry
`define BSP_WORD_W      18
`define BSP_LANE_W      9
`define BSP_LANES       2
`define BSP_ADDR_W      21
`define BSP_ARRAYS      4
`define BSP_BURST_LEN   4

// =====================================================================
// Buffering and timing
`define BSP_FIFO_DEPTH  2
`define BSP_PLL_ON_WAIT 1

// =====================================================================
// Reset values
`define BSP_Q_RST       18'h0_0000

`endif

// file: verilog/bsp_pkg.sv
// Types of the split-port burst memory block
`include "bsp_regs.svh"

package bsp_pkg;

    // Read sequencer states, one-hot
    typedef enum logic [3:0] {
        BSP_RD_IDLE  = 4'h1,
        BSP_RD_WAIT  = 4'h2,
        BSP_RD_ISSUE = 4'h4,
        BSP_RD_PUSH  = 4'h8
    } bsp_rd_state_e;

    // One write beat as seen on the pins
    typedef struct packed {
        logic [`BSP_LANES-1:0]  lane_n;
        logic [`BSP_WORD_W-1:0] data;
    } bsp_wr_beat_s;

endpackage

// file: verilog/bsp_mem.sv
// Storage array with lane-masked write and registered read
`timescale 1ns/1ns
`include "bsp_regs.svh"

module bsp_mem #(
    parameter int AW    = 23,
    parameter int DW    = `BSP_WORD_W,
    parameter int LANES = `BSP_LANES
) (
    // Clock
    input  wire logic             clk_i,
    // Write port
    input  wire logic             we_i,
    input  wire logic [LANES-1:0] wbe_i,
    input  wire logic [AW-1:0]    waddr_i,
    input  wire logic [DW-1:0]    wdata_i,
    // Read port
    input  wire logic             re_i,
    input  wire logic [AW-1:0]    raddr_i,
    output logic      [DW-1:0]    rdata_o
);

    localparam int LW = DW / LANES;

    if (DW % LANES != 0 || AW < 1) begin : g_bad_geometry
        $error("bsp_mem: width must split evenly into lanes");
    end

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            for (int l = 0; l < LANES; l++) begin
                if (wbe_i[l]) begin
                    mem[waddr_i][l*LW +: LW] <= wdata_i[l*LW +: LW];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (re_i) begin
            rdata_o <= mem[raddr_i];
        end
    end

endmodule

// file: verilog/bsp_core.sv
// Pin-level core of the split-port burst memory
`timescale 1ns/1ns
`include "bsp_regs.svh"

module bsp_core
    import bsp_pkg::*;
#(
    parameter int ADDR_W     = `BSP_ADDR_W,
    parameter int FIFO_DEPTH = `BSP_FIFO_DEPTH
) (
    // Input clock domain
    input  wire logic                   clk_sys_i,
    input  wire logic                   rstn_i,
    // Output data clock domain
    input  wire logic                   clk_out_c_i,
    // Control pins
    input  wire logic                   write_port_select_n_i,
    input  wire logic                   read_port_select_n_i,
    input  wire logic                   pll_disable_n_i,
    // Address and write data pins
    input  wire logic [ADDR_W-1:0]      addr_i,
    input  wire logic [`BSP_WORD_W-1:0] wdata_i,
    input  wire logic [`BSP_LANES-1:0]  byte_lane_write_select_n_i,
    // Read data pins
    output logic      [`BSP_WORD_W-1:0] read_data_o,
    output logic                        read_data_oe_n_o
);

    localparam int BEAT_W = $clog2(`BSP_BURST_LEN);
    localparam int MEM_AW = ADDR_W + BEAT_W;
    localparam int PTR_W  = $clog2(FIFO_DEPTH) + 1;
    localparam logic [BEAT_W-1:0] LAST_BEAT = BEAT_W'(`BSP_BURST_LEN - 1);
    localparam logic [PTR_W-1:0]  FULL_CNT  = PTR_W'(FIFO_DEPTH);

    // =================================================================
    // Elaboration checks
    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
        $error("bsp_core: FIFO_DEPTH must be a power of two, at least 2");
    end
    if (ADDR_W < 1 || ADDR_W > `BSP_ADDR_W) begin : g_bad_addr
        $error("bsp_core: ADDR_W out of range");
    end
    if (`BSP_LANES * `BSP_LANE_W != `BSP_WORD_W) begin : g_bad_lanes
        $error("bsp_core: lanes do not cover the word");
    end

    function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b[PTR_W-1] = g[PTR_W-1];
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // =================================================================
    // Static strap synchroniser
    logic pll_s1_q;
    logic pll_on_q;

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            pll_s1_q <= 1'b1;
            pll_on_q <= 1'b1;
        end else begin
            pll_s1_q <= pll_disable_n_i;
            pll_on_q <= pll_s1_q;
        end
    end

    // =================================================================
    // Write port
    bsp_wr_beat_s            wr_in;
    logic                    wr_active_q;
    logic [BEAT_W-1:0]       wr_beat_q;
    logic [ADDR_W-1:0]       wr_addr_q;
    logic                    wr_start;
    logic                    mem_we;
    logic [MEM_AW-1:0]       mem_waddr;

    assign wr_in     = '{lane_n: byte_lane_write_select_n_i, data: wdata_i};
    assign wr_start  = !wr_active_q && !write_port_select_n_i;
    assign mem_we    = wr_start || wr_active_q;
    assign mem_waddr = wr_start ? {addr_i, BEAT_W'(0)} : {wr_addr_q, wr_beat_q};

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            wr_active_q <= 1'b0;
        end else if (wr_start) begin
            wr_active_q <= 1'b1;
        end else if (wr_active_q && wr_beat_q == LAST_BEAT) begin
            wr_active_q <= 1'b0;
        end
    end

    // Beat counter wraps to zero after the fourth beat
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            wr_beat_q <= '0;
        end else if (wr_start) begin
            wr_beat_q <= BEAT_W'(1);
        end else if (wr_active_q) begin
            wr_beat_q <= wr_beat_q + BEAT_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            wr_addr_q <= '0;
        end else if (wr_start) begin
            wr_addr_q <= addr_i;
        end
    end

    // =================================================================
    // Read sequencer
    bsp_rd_state_e              rd_state_q;
    logic [ADDR_W-1:0]          rd_addr_q;
    logic [BEAT_W-1:0]          rd_beat_q;
    logic                       mem_re;
    logic [`BSP_WORD_W-1:0]     mem_rdata;
    logic                       push_valid;
    logic                       push_ready;

    assign mem_re     = (rd_state_q == BSP_RD_ISSUE);
    assign push_valid = (rd_state_q == BSP_RD_PUSH);

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rd_state_q <= BSP_RD_IDLE;
        end else begin
            case (rd_state_q)
                BSP_RD_IDLE: begin
                    if (!read_port_select_n_i) begin
                        rd_state_q <= pll_on_q ? BSP_RD_WAIT : BSP_RD_ISSUE;
                    end
                end
                BSP_RD_WAIT: begin
                    rd_state_q <= BSP_RD_ISSUE;
                end
                BSP_RD_ISSUE: begin
                    rd_state_q <= BSP_RD_PUSH;
                end
                BSP_RD_PUSH: begin
                    if (push_ready) begin
                        rd_state_q <= (rd_beat_q == LAST_BEAT) ? BSP_RD_IDLE
                                                               : BSP_RD_ISSUE;
                    end
                end
                default: begin
                    rd_state_q <= BSP_RD_IDLE;
                end
            endcase
        end
    end

    // Burst address taken once, beat advances on each accepted push
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rd_addr_q <= '0;
            rd_beat_q <= '0;
        end else if (rd_state_q == BSP_RD_IDLE && !read_port_select_n_i) begin
            rd_addr_q <= addr_i;
            rd_beat_q <= '0;
        end else if (push_valid && push_ready) begin
            rd_beat_q <= rd_beat_q + BEAT_W'(1);
        end
    end

    // =================================================================
    // Storage
    // A read of a word written on the same edge returns old contents
    bsp_mem #(
        .AW    (MEM_AW),
        .DW    (`BSP_WORD_W),
        .LANES (`BSP_LANES)
    ) u_mem (
        .clk_i   (clk_sys_i),
        .we_i    (mem_we),
        .wbe_i   (~wr_in.lane_n),
        .waddr_i (mem_waddr),
        .wdata_i (wr_in.data),
        .re_i    (mem_re),
        .raddr_i ({rd_addr_q, rd_beat_q}),
        .rdata_o (mem_rdata)
    );

    // =================================================================
    // Read buffer, filling side on the input clock
    logic [`BSP_WORD_W-1:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0]       wptr_bin_q;
    logic [PTR_W-1:0]       wptr_gray_q;
    logic [PTR_W-1:0]       rg_s1_q;
    logic [PTR_W-1:0]       rg_s2_q;
    logic [PTR_W-1:0]       rptr_gray_c_q;
    logic [PTR_W-1:0]       wptr_next;

    // Full when a whole buffer depth is ahead of the reader
    assign push_ready = (wptr_bin_q - gray2bin(rg_s2_q)) != FULL_CNT;
    assign wptr_next  = wptr_bin_q + PTR_W'(1);

    // Read pointer synchroniser
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rg_s1_q <= '0;
            rg_s2_q <= '0;
        end else begin
            rg_s1_q <= rptr_gray_c_q;
            rg_s2_q <= rg_s1_q;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            wptr_bin_q <= '0;
        end else if (push_valid && push_ready) begin
            wptr_bin_q <= wptr_next;
        end
    end

    // Gray copy is the only pointer that crosses to the output clock
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            wptr_gray_q <= '0;
        end else if (push_valid && push_ready) begin
            wptr_gray_q <= wptr_next ^ (wptr_next >> 1);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (push_valid && push_ready) begin
            fifo_mem[wptr_bin_q[PTR_W-2:0]] <= mem_rdata;
        end
    end

    // =================================================================
    // Output clock domain
    logic                   c_rst_s1_q;
    logic                   c_rstn_q;
    logic [PTR_W-1:0]       wg_s1_q;
    logic [PTR_W-1:0]       wg_s2_q;
    logic [PTR_W-1:0]       rptr_bin_c_q;
    logic [PTR_W-1:0]       rptr_next;
    logic                   pop_valid;

    assign pop_valid = (rptr_gray_c_q != wg_s2_q);
    assign rptr_next = rptr_bin_c_q + PTR_W'(1);

    // Reset crossing into the output clock
    always_ff @(posedge clk_out_c_i) begin
        c_rst_s1_q <= rstn_i;
        c_rstn_q   <= c_rst_s1_q;
    end

    // Write pointer synchroniser
    always_ff @(posedge clk_out_c_i) begin
        if (!c_rstn_q) begin
            wg_s1_q <= '0;
            wg_s2_q <= '0;
        end else begin
            wg_s1_q <= wptr_gray_q;
            wg_s2_q <= wg_s1_q;
        end
    end

    always_ff @(posedge clk_out_c_i) begin
        if (!c_rstn_q) begin
            rptr_bin_c_q <= '0;
        end else if (pop_valid) begin
            rptr_bin_c_q <= rptr_next;
        end
    end

    // Gray copy goes back to the input clock
    always_ff @(posedge clk_out_c_i) begin
        if (!c_rstn_q) begin
            rptr_gray_c_q <= '0;
        end else if (pop_valid) begin
            rptr_gray_c_q <= rptr_next ^ (rptr_next >> 1);
        end
    end

    always_ff @(posedge clk_out_c_i) begin
        if (!c_rstn_q) begin
            read_data_o <= `BSP_Q_RST;
        end else if (pop_valid) begin
            read_data_o <= fifo_mem[rptr_bin_c_q[PTR_W-2:0]];
        end
    end

    // Drivers stay on while words remain, release one edge after
    always_ff @(posedge clk_out_c_i) begin
        if (!c_rstn_q) begin
            read_data_oe_n_o <= 1'b1;
        end else begin
            read_data_oe_n_o <= !pop_valid;
        end
    end

endmodule

// file: bench/bsp_core_asserts.sv
// Checker of the core's read pins
`timescale 1ns/1ns
`include "bsp_regs.svh"

module bsp_core_asserts
    import bsp_pkg::*;
#(
    parameter int ADDR_W = `BSP_ADDR_W
) (
    // Clocks and reset
    input wire logic                   clk_sys_i,
    input wire logic                   rstn_i,
    input wire logic                   clk_out_c_i,
    // Pins
    input wire logic                   write_port_select_n_i,
    input wire logic                   read_port_select_n_i,
    input wire logic                   pll_disable_n_i,
    input wire logic [ADDR_W-1:0]      addr_i,
    input wire logic [`BSP_WORD_W-1:0] wdata_i,
    input wire logic [`BSP_LANES-1:0]  byte_lane_write_select_n_i,
    input wire logic [`BSP_WORD_W-1:0] read_data_o,
    input wire logic                   read_data_oe_n_o
);
    // ==========================================================
    // Cycles since last read select, beats seen since then
    logic [4:0] rd_idle_q;
    logic [2:0] beat_q;

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i)
            rd_idle_q <= 5'h1f;
        else if (!read_port_select_n_i)
            rd_idle_q <= 5'h00;
        else if (rd_idle_q != 5'h1f)
            rd_idle_q <= rd_idle_q + 5'h01;
    end

    always_ff @(posedge clk_out_c_i) begin
        if (!rstn_i || rd_idle_q < 5'h02)
            beat_q <= 3'h0;
        else if (!read_data_oe_n_o)
            beat_q <= beat_q + 3'h1;
    end

    // ==========================================================
    // Properties
    sequence rd_start_s;
        !read_port_select_n_i && rd_idle_q == 5'h1f;
    endsequence

    sequence quiet3_s;
        read_data_oe_n_o [*3];
    endsequence

    reset_oe_off_a: assert property (@(posedge clk_out_c_i)
        !rstn_i [*4] |-> read_data_oe_n_o) else $error("driver on in reset");
    reset_data_zero_a: assert property (@(posedge clk_out_c_i)
        !rstn_i [*4] |-> read_data_o == `BSP_Q_RST) else $error("data not cleared");
    first_beat_late_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        rd_start_s |-> quiet3_s) else $error("read data too early");
    read_answer_bound_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        rd_start_s |-> ##[1:25] !read_data_oe_n_o) else $error("read not answered");
    burst_count_max_a: assert property (@(posedge clk_out_c_i) disable iff (!rstn_i)
        beat_q <= 3'h4) else $error("too many beats");
    burst_count_full_a: assert property (@(posedge clk_out_c_i) disable iff (!rstn_i)
        $rose(rd_idle_q == 5'h1f) |-> beat_q == 3'h4) else $error("burst short");
    idle_release_a: assert property (@(posedge clk_out_c_i) disable iff (!rstn_i)
        rd_idle_q == 5'h1f |-> read_data_oe_n_o) else $error("driver left on");
    post_reset_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $rose(rstn_i) |-> read_data_oe_n_o [*4]) else $error("driver on after reset");
endmodule

bind bsp_core bsp_core_asserts #(.ADDR_W(ADDR_W)) u_chk (
    .clk_sys_i, .rstn_i, .clk_out_c_i, .write_port_select_n_i, .read_port_select_n_i,
    .pll_disable_n_i, .addr_i, .wdata_i, .byte_lane_write_select_n_i, .read_data_o,
    .read_data_oe_n_o);

// file: bench/bsp_ctl_model.sv
// Behavioural memory controller driving the core's pins
`timescale 1ns/1ns
`include "bsp_regs.svh"

module bsp_ctl_model
    import bsp_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    // Clocks
    input  wire logic                   clk_sys_i,
    input  wire logic                   clk_out_c_i,
    // Request pins
    output logic                        write_port_select_n_o,
    output logic                        read_port_select_n_o,
    output logic      [ADDR_W-1:0]      addr_o,
    output bsp_wr_beat_s                beat_o,
    // Read return
    input  wire logic [`BSP_WORD_W-1:0] read_data_i,
    input  wire logic                   read_data_oe_n_i
);
    logic [`BSP_WORD_W-1:0] rd_q[$];
    logic                   busy;

    initial begin
        write_port_select_n_o = 1'b1;
        read_port_select_n_o = 1'b1;
        addr_o = '0;
        beat_o = '0;
        busy = 1'b0;
    end

    // Released address and beat lines toggle so a stale value never looks valid
    always @(negedge clk_sys_i) begin
        if (!busy) begin
            addr_o <= ~addr_o;
            beat_o <= ~beat_o;
        end
    end

    always @(posedge clk_out_c_i) begin
        if (!read_data_oe_n_i)
            rd_q.push_back(read_data_i);
    end

    task automatic write_burst(input logic [ADDR_W-1:0] a, input logic [71:0] d,
                               input logic [7:0] ln);
        busy = 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(negedge clk_sys_i);
            write_port_select_n_o <= (k != 0);
            addr_o <= (k == 0) ? a : ~a;
            beat_o <= {ln[2*k+:2], d[18*k+:18]};
        end
        // Last beat must stand at the sampling edge before toggling resumes
        @(posedge clk_sys_i);
        busy = 1'b0;
    endtask

    task automatic read_burst(input logic [ADDR_W-1:0] a, input logic twice);
        busy = 1'b1;
        @(negedge clk_sys_i);
        read_port_select_n_o <= 1'b0;
        addr_o <= a;
        @(negedge clk_sys_i);
        read_port_select_n_o <= !twice;
        addr_o <= ~a;
        @(negedge clk_sys_i);
        read_port_select_n_o <= 1'b1;
        @(posedge clk_sys_i);
        busy = 1'b0;
    endtask
endmodule

// file: bench/burst_sram_split_port_io_test.sv
// Self-checking bench of the split-port burst memory core
`timescale 1ns/1ns
`include "bsp_regs.svh"

module burst_sram_split_port_io_test
    import bsp_pkg::*;
;
    localparam int AW = 6;
    typedef struct packed {
        logic          pll;
        logic [AW-1:0] a;
        logic [17:0]   d;
        logic [7:0]    ln;
    } bsp_row_s;

    logic                   clk_sys_i;
    logic                   clk_out_c_i;
    logic                   rstn_i;
    logic                   pll_disable_n_i;
    logic                   wps_n;
    logic                   rps_n;
    logic                   oe_n;
    logic [AW-1:0]          addr;
    bsp_wr_beat_s           beat;
    logic [`BSP_WORD_W-1:0] rdata;
    logic [17:0]            mem [logic [AW+1:0]];
    int                     fail_count;
    int                     checks_done;
    bsp_row_s               rows [5] = '{
        '{1'b1, 6'h05, 18'h1_2345, 8'h00},
        '{1'b1, 6'h05, 18'h2_abcd, 8'h1b},
        '{1'b0, 6'h3f, 18'h3_ffff, 8'h00},
        '{1'b0, 6'h00, 18'h0_0001, 8'h00},
        '{1'b0, 6'h3f, 18'h1_5555, 8'he4}};

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        clk_out_c_i = 1'b0;
        #3;
        forever #6 clk_out_c_i = ~clk_out_c_i;
    end

    bsp_core #(.ADDR_W(AW)) dut (
        .clk_sys_i, .rstn_i, .clk_out_c_i, .pll_disable_n_i,
        .write_port_select_n_i(wps_n), .read_port_select_n_i(rps_n), .addr_i(addr),
        .wdata_i(beat.data), .byte_lane_write_select_n_i(beat.lane_n),
        .read_data_o(rdata), .read_data_oe_n_o(oe_n));

    bsp_ctl_model #(.ADDR_W(AW)) ctl (
        .clk_sys_i, .clk_out_c_i, .write_port_select_n_o(wps_n),
        .read_port_select_n_o(rps_n), .addr_o(addr), .beat_o(beat),
        .read_data_i(rdata), .read_data_oe_n_i(oe_n));

    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic do_write(input logic [AW-1:0] a, input logic [17:0] d,
                            input logic [7:0] ln);
        logic [71:0] beats;
        for (int k = 0; k < 4; k++) begin
            beats[18*k+:18] = d + 18'(k * 18'h0_1111);
            for (int j = 0; j < 2; j++)
                if (!ln[2*k+j])
                    mem[{a, 2'(k)}][9*j+:9] = beats[18*k+9*j+:9];
        end
        ctl.write_burst(a, beats, ln);
    endtask

    task automatic do_read(input logic [AW-1:0] a, input logic twice);
        ctl.rd_q.delete();
        ctl.read_burst(a, twice);
        repeat (40) @(posedge clk_sys_i);
        check(18'(ctl.rd_q.size()), 18'h0_0004);
        for (int k = 0; k < 4 && k < ctl.rd_q.size(); k++)
            check(ctl.rd_q[k], mem[{a, 2'(k)}]);
    endtask

    initial begin
        rstn_i = 1'b0;
        pll_disable_n_i = 1'b1;
        fail_count = 0;
        checks_done = 0;
        repeat (5) @(posedge clk_sys_i);
        check(18'(oe_n), 18'h0_0001);
        check(rdata, `BSP_Q_RST);
        @(negedge clk_sys_i) rstn_i = 1'b1;
        foreach (rows[i]) begin
            @(negedge clk_sys_i) pll_disable_n_i = rows[i].pll;
            repeat (4) @(negedge clk_sys_i);
            do_write(rows[i].a, rows[i].d, rows[i].ln);
            do_read(rows[i].a, 1'b0);
        end
        // Back-to-back writes, then two reads, the second with a second select mid-fetch
        do_write(6'h10, 18'h2_4680, 8'h00);
        do_write(6'h11, 18'h1_3579, 8'h00);
        do_read(6'h10, 1'b0);
        do_read(6'h11, 1'b1);
        wrap_up();
    end

    initial begin
        #50000;
        fail_count++;
        wrap_up();
    end
endmodule
